// ---- adc_ctrl_map.vh ----
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// Register indices (byte address = index * 4)
`define REG_GAIN        4'h0
`define REG_OFFCTL      4'h1
`define REG_PWR         4'h2
`define REG_STATUS      4'h3
`define REG_OFFEST      4'h4
// Field layout
`define GAIN_W          4
`define GAIN_MAX        4'hC
`define GAIN_RST        4'h0
`define OFF_EN_BIT      4
`define TC_LSB          0
`define TC_W            4
`define TC_MAX          4'hB
`define TC_LOCK         4'h0
`define PWR_SLEEP_BIT   0
`define PWR_STBY_BIT    1
`define PWR_ODOFF_BIT   2
`define PWR_RST         3'h0
`define DATA_W          14
`define EST_FRAC        30
`define EST_W           44
// Offset correction limit in codes (about 10 mV of 2 V at 14 bits)
`define OFF_LIMIT       14'h0052
// Timing
`define CLK_NS          50
`define SLEEP_WAKE_NS   25000
`define STBY_WAKE_NS    300
`define ODOFF_WAKE_NS   40
// Wake counts in clock cycles: 25000 ns and 300 ns over 50 ns
`define SLEEP_WAKE_CYC  10'h1F4
`define STBY_WAKE_CYC   10'h006
`define ODOFF_WAKE_CYC  1
`define CNT_W           10
`define TC_BASE_LOG2    6'h12
`endif

// ---- adc_gain_offset_power_ctrl.v ----
`timescale 1ns/1ns
`include "adc_ctrl_map.vh"
module adc_gain_offset_power_ctrl (
   // Clock and reset
   input  wire                 i_clock,
   input  wire                 i_rst,
   // Register port
   input  wire [3:0]           i_addr,
   input  wire [31:0]          i_wdata,
   input  wire                 i_wr,
   input  wire                 i_rd,
   output reg  [31:0]          o_rdata,
   // Configuration pins
   input  wire                 i_parallel_mode,
   input  wire                 i_serial_data_pin,
   // Converter data path
   input  wire [`DATA_W-1:0]   i_sample,
   output reg  [`DATA_W-1:0]   o_data,
   output wire                 o_data_oe,
   output wire                 o_data_valid,
   // Analog controls
   output wire [`GAIN_W-1:0]   o_gain_code,
   output wire                 o_adc_power_on,
   output wire                 o_ref_power_on,
   output wire                 o_driver_power_on
);

   reg  [`GAIN_W-1:0]  gain_ff;
   reg                 off_en_ff;
   reg  [`TC_W-1:0]    tc_ff;
   reg                 sleep_bit_ff;
   reg                 stby_bit_ff;
   reg                 odoff_bit_ff;
   reg  [2:0]          pin_sync_ff;
   reg                 pin_level_ff;
   reg  [`EST_W-1:0]   est_ff;
   reg  [`CNT_W-1:0]   wake_cnt_ff;
   reg                 prev_sleep_ff;
   reg                 prev_stby_ff;
   reg                 prev_odoff_ff;
   wire                full_chip_sleep;
   wire                standby;
   wire                output_driver_off;
   wire                locked;
   wire [`DATA_W-1:0]  est_int;
   wire [`DATA_W-1:0]  corr;
   wire [`DATA_W-1:0]  err;
   wire [`EST_W-1:0]   err_ext;
   wire signed [`EST_W-1:0] est_step;
   wire [5:0]          shift;
   reg  [`EST_W-1:0]   nxt_est;
   reg  [`CNT_W-1:0]   nxt_wake_cnt;

   // Pin synchroniser: change counts once stages two and three agree
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pin_sync_ff  <= 3'h0;
         pin_level_ff <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], i_serial_data_pin};
         if (pin_sync_ff[2] == pin_sync_ff[1])
            pin_level_ff <= pin_sync_ff[2];
      end
   end

   // Sleep from the pin in parallel mode, else the register
   assign full_chip_sleep = i_parallel_mode ? pin_level_ff
                                            : sleep_bit_ff;
   // Sleep overrides standby
   assign standby = stby_bit_ff & ~full_chip_sleep;
   assign output_driver_off = odoff_bit_ff;

   // Register writes; gain codes above the top are clipped, not stored
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         gain_ff      <= `GAIN_RST;
         off_en_ff    <= 1'b0;
         tc_ff        <= `TC_LOCK;
         sleep_bit_ff <= 1'b0;
         stby_bit_ff  <= 1'b0;
         odoff_bit_ff <= 1'b0;
      end else if (i_wr) begin
         case (i_addr)
            `REG_GAIN: begin
               if (i_wdata[`GAIN_W-1:0] > `GAIN_MAX)
                  gain_ff <= `GAIN_MAX;
               else
                  gain_ff <= i_wdata[`GAIN_W-1:0];
            end
            `REG_OFFCTL: begin
               off_en_ff <= i_wdata[`OFF_EN_BIT];
               tc_ff     <= i_wdata[`TC_LSB+`TC_W-1:`TC_LSB];
            end
            `REG_PWR: begin
               sleep_bit_ff <= i_wdata[`PWR_SLEEP_BIT];
               stby_bit_ff  <= i_wdata[`PWR_STBY_BIT];
               odoff_bit_ff <= i_wdata[`PWR_ODOFF_BIT];
            end
            default: ;
         endcase
      end
   end

   // Gain code drives the analog full-scale scaling (2 V .. 1 V)
   assign o_gain_code = gain_ff;

   // Loop: est += (err - est) >> shift; shift 18+code. Reserved
   // codes hold the estimate, same as lock, rather than guessing
   assign locked  = (tc_ff == `TC_LOCK) | (tc_ff > `TC_MAX);
   assign shift   = `TC_BASE_LOG2 + {2'b00, tc_ff};
   assign est_int = est_ff[`EST_W-1:`EST_FRAC];
   assign err     = i_sample;
   assign err_ext = {err, {`EST_FRAC{1'b0}}};

   // Step kept signed on its own so the shift stays arithmetic;
   // mixed with the unsigned estimate it would shift in zeros
   assign est_step = $signed(err_ext - est_ff) >>> shift;

   // Estimate update; lock and reserved codes hold the estimate
   always @* begin
      nxt_est = est_ff;
      if (off_en_ff && !locked && !full_chip_sleep && !standby)
         nxt_est = est_ff + est_step;
   end

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst)
         est_ff <= {`EST_W{1'b0}};
      else
         est_ff <= nxt_est;
   end

   // Clamp correction to the offset range
   assign corr = ($signed(est_int) > $signed(`OFF_LIMIT))
                 ? `OFF_LIMIT
                 : ($signed(est_int) < -$signed(`OFF_LIMIT))
                   ? (~`OFF_LIMIT + 14'h0001)
                   : est_int;

   // Output data: correction subtracted every cycle when enabled
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst)
         o_data <= {`DATA_W{1'b0}};
      else if (off_en_ff)
         o_data <= i_sample - corr;
      else
         o_data <= i_sample;
   end

   // Wake-up counter: reloads on leaving sleep or standby, longest wins
   always @* begin
      nxt_wake_cnt = wake_cnt_ff;
      if (full_chip_sleep || standby)
         nxt_wake_cnt = {`CNT_W{1'b0}};
      else if (prev_sleep_ff)
         nxt_wake_cnt = `SLEEP_WAKE_CYC;
      else if (prev_stby_ff && wake_cnt_ff < `STBY_WAKE_CYC)
         nxt_wake_cnt = `STBY_WAKE_CYC;
      else if (wake_cnt_ff != {`CNT_W{1'b0}})
         nxt_wake_cnt = wake_cnt_ff - 10'h001;
   end

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wake_cnt_ff   <= {`CNT_W{1'b0}};
         prev_sleep_ff <= 1'b0;
         prev_stby_ff  <= 1'b0;
         prev_odoff_ff <= 1'b0;
      end else begin
         wake_cnt_ff   <= nxt_wake_cnt;
         prev_sleep_ff <= full_chip_sleep;
         prev_stby_ff  <= standby;
         prev_odoff_ff <= output_driver_off;
      end
   end

   // Power rails per mode
   assign o_adc_power_on    = ~full_chip_sleep & ~standby;
   assign o_ref_power_on    = ~full_chip_sleep;
   assign o_driver_power_on = ~full_chip_sleep;
   // Drivers hi-Z in sleep or when switched off
   assign o_data_oe = ~full_chip_sleep & ~output_driver_off;
   assign o_data_valid = o_data_oe & o_adc_power_on
                         & (wake_cnt_ff == {`CNT_W{1'b0}})
                         & ~prev_sleep_ff & ~prev_stby_ff
                         & ~prev_odoff_ff;
   // One cycle (50 ns) after drivers return covers the 40 ns wake

   // Read data, one cycle after the strobe
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst)
         o_rdata <= 32'h0000_0000;
      else if (i_rd) begin
         case (i_addr)
            `REG_GAIN:   o_rdata <= {28'h000_0000, gain_ff};
            `REG_OFFCTL: o_rdata <= {27'h000_0000, off_en_ff, tc_ff};
            `REG_PWR:    o_rdata <= {29'h0000_0000, odoff_bit_ff,
                                     stby_bit_ff, sleep_bit_ff};
            `REG_STATUS: o_rdata <= {29'h0000_0000, o_data_valid,
                                     locked, full_chip_sleep};
            `REG_OFFEST: o_rdata <= {18'h0_0000, est_int};
            default:     o_rdata <= 32'h0000_0000;
         endcase
      end else
         o_rdata <= 32'h0000_0000;
   end

endmodule

// ---- adc_ctrl_chk_asserts.sv ----
`timescale 1ns/1ns
module adc_ctrl_chk (
   // Clock and reset
   input wire       i_clock,
   input wire       i_rst,
   // Pins and watched outputs
   input wire       i_parallel_mode,
   input wire       i_serial_data_pin,
   input wire       o_data_oe,
   input wire       o_data_valid,
   input wire [3:0] o_gain_code,
   input wire       o_adc_power_on,
   input wire       o_ref_power_on,
   input wire       o_driver_power_on
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Wake starts: full sleep ends, or standby ends on its own
   sequence s_sleep_end;
      $rose(o_ref_power_on);
   endsequence
   sequence s_stby_end;
      $rose(o_adc_power_on) && $past(o_ref_power_on);
   endsequence
   AST_GAIN_MAX: assert property (o_gain_code <= 4'hC)
      else $error("gain above 6 dB");
   AST_SLEEP_OFF: assert property (!o_ref_power_on |->
      !o_adc_power_on && !o_driver_power_on && !o_data_oe)
      else $error("sleep left something powered");
   AST_STBY_OFF: assert property (!o_adc_power_on |-> !o_data_valid)
      else $error("valid while converter off");
   AST_DRV_OFF: assert property (!o_driver_power_on |-> !o_data_oe)
      else $error("drivers enabled while off");
   AST_SLEEP_WAKE: assert property (s_sleep_end |-> ##[1:520] o_data_valid)
      else $error("slow sleep wake");
   AST_STBY_WAKE: assert property (s_stby_end |->
      !o_data_valid [*5] ##[1:4] o_data_valid)
      else $error("standby wake timing");
   AST_DRV_WAKE: assert property ($rose(o_data_oe) &&
      o_adc_power_on && $past(o_adc_power_on) |-> ##[1:2] o_data_valid)
      else $error("slow driver wake");
   AST_PIN_SLEEP: assert property (
      (i_parallel_mode && i_serial_data_pin) [*5] |-> !o_ref_power_on)
      else $error("pin sleep ignored");
endmodule

bind adc_gain_offset_power_ctrl adc_ctrl_chk chk (
   .i_clock, .i_rst, .i_parallel_mode, .i_serial_data_pin, .o_data_oe,
   .o_data_valid, .o_gain_code, .o_adc_power_on, .o_ref_power_on,
   .o_driver_power_on);

// ---- test_adc_gain_offset_power_ctrl.sv ----
`timescale 1ns/1ns
`include "adc_ctrl_map.vh"
module test_adc_gain_offset_power_ctrl;
   // Bench drive and design outputs
   reg         i_clock, i_rst, i_wr, i_rd, i_parallel_mode;
   reg         i_serial_data_pin, rd_d;
   reg  [3:0]  i_addr;
   reg  [31:0] i_wdata, g, expq[$];
   reg  [13:0] i_sample, prev;
   wire [31:0] o_rdata;
   wire [13:0] o_data;
   wire [3:0]  o_gain_code;
   wire        o_data_oe, o_data_valid, o_adc_power_on;
   wire        o_ref_power_on, o_driver_power_on;
   wire [3:0]  pw = {o_ref_power_on, o_adc_power_on, o_driver_power_on,
                     o_data_valid};
   integer     seed = 32'h3aec, fails = 0, comparisons = 0, i;
   adc_gain_offset_power_ctrl DUT (
      .i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_parallel_mode, .i_serial_data_pin, .i_sample, .o_data,
      .o_data_oe, .o_data_valid, .o_gain_code, .o_adc_power_on,
      .o_ref_power_on, .o_driver_power_on);
   // 20 MHz clock
   initial begin
      i_clock = 0;
      forever #25 i_clock = ~i_clock;
   end
   task chk(input string nm, input [31:0] e, input [31:0] v);
      begin
         comparisons = comparisons + 1;
         if (v !== e) begin
            fails = fails + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, e, v);
         end
      end
   endtask
   // One bus cycle; a read only notes its expected data
   task acc(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge i_clock);
         {i_wr, i_rd, i_addr, i_wdata} <= {w, !w, a, w ? d : 32'h0000_0000};
         if (!w) expq.push_back(d);
         @(posedge i_clock);
         {i_wr, i_rd} <= 2'b00;
      end
   endtask
   // Step past the edge so its updates have landed
   task wt(input integer n);
      begin
         repeat (n) @(posedge i_clock);
         #1;
      end
   endtask
   task finish_test;
      begin
         $display("comparisons %0d fails %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // Fresh samples each cycle; read data matched a cycle after its strobe
   always @(posedge i_clock) begin
      i_sample <= 14'($random(seed));
      prev <= i_sample;
      rd_d <= i_rd;
      if (rd_d)
         chk("rdata", expq.pop_front(), o_rdata);
   end
   initial begin
      {i_rst, i_wr, i_rd, i_parallel_mode, i_serial_data_pin} = 5'h10;
      {i_addr, i_wdata} = 36'h0;
      repeat (3) @(posedge i_clock);
      i_rst <= 0;
      // Reset state, samples pass through untouched
      acc(0, `REG_GAIN, 32'h0000_0000);
      acc(0, `REG_OFFCTL, 32'h0000_0000);
      acc(0, `REG_STATUS, 32'h0000_0006);
      wt(1);
      chk("data", {18'h0, prev}, {18'h0, o_data});
      $display("reset test done");
      // Every gain code, the top ones clipped to 6 dB
      for (i = 0; i < 16; i = i + 1) begin
         g = (i > 12) ? 12 : i;
         acc(1, `REG_GAIN, i);
         acc(0, `REG_GAIN, g);
         chk("gain", g, {28'h0, o_gain_code});
      end
      $display("gain test done");
      // Random live time constant, then reserved codes and zero lock
      g = 32'h0000_0010 | ({$random(seed)} % 11 + 1);
      acc(1, `REG_OFFCTL, g);
      acc(0, `REG_OFFCTL, g);
      for (i = 11; i < 17; i = i + 1) begin
         acc(1, `REG_OFFCTL, 16 + i % 16);
         acc(0, `REG_STATUS, (i == 11) ? 4 : 6);
      end
      acc(1, `REG_OFFCTL, 32'h0000_0000);
      $display("offset test done");
      // Each power mode, an early look (too early except for driver off), then full recovery
      for (i = 1; i < 5; i = i + 1) begin
         acc(1, `REG_PWR, i);
         wt(1);
         chk("power", 16'hE0A0 >> i * 4 - 4 & 15, pw);
         chk("oe", i == 2, o_data_oe);
         acc(1, `REG_PWR, 32'h0000_0000);
         wt(i == 1 ? 400 : i == 2 ? 4 : i == 3 ? 10 : 3);
         chk("early", i == 4, o_data_valid);
         wt(520);
         chk("wake", 1, o_data_valid);
      end
      $display("power test done");
      // Full sleep from the serial data pin in parallel mode
      @(posedge i_clock);
      {i_parallel_mode, i_serial_data_pin} <= 2'b11;
      wt(8);
      chk("pin", 0, o_ref_power_on);
      @(posedge i_clock);
      i_serial_data_pin <= 0;
      wt(520);
      chk("pin", 1, o_data_valid);
      acc(0, 4'h9, 32'h0000_0000);
      $display("pin test done");
      wt(2);
      finish_test;
   end
   // Watchdog: the run needs about 3000 cycles
   initial begin
      #400000;
      fails = fails + 1;
      finish_test;
   end
endmodule
